// ### pkg/sync_gate_pkg.sv
/*
 * Constants shared by the alignment-pulse gating block: register offsets,
 * field positions, reset values.
 * Assumes 8-bit registers reached by an 8-bit address on the sample clock.
 */
package sync_gate_pkg;
   // Register offsets
   localparam logic [7:0] ADDR_MASTER_SYNC  = 8'h3a;
   localparam logic [7:0] ADDR_PHASE_HI     = 8'h56;
   localparam logic [7:0] ADDR_PHASE_LO     = 8'h57;
   localparam logic [7:0] ADDR_STAGE_SYNC   = 8'h58;
   localparam logic [7:0] ADDR_PIN_SENSE    = 8'h59;
   localparam logic [7:0] ADDR_LATENCY_SEL  = 8'h5a;

   // Field positions
   localparam int MASTER_EN_BIT   = 0;
   localparam int PIN_EDGE_BIT    = 0;
   localparam int PIN_SENSE_BIT   = 1;
   localparam int LOW_LAT_BIT     = 0;
   localparam int NUM_STAGES      = 3;
   localparam int STAGE_OSC       = 0;
   localparam int STAGE_FILTER    = 1;
   localparam int STAGE_QUARTER   = 2;
   // Enable bit per stage; its next-sync-only bit sits one above
   localparam int STAGE_EN_BIT [NUM_STAGES] = '{0, 4, 6};

   // Writable bits of the stage sync register; bits 3:2 are reserved
   localparam logic [7:0] STAGE_SYNC_MASK   = 8'hf3;

   // Values after reset
   localparam logic [7:0]  RST_STAGE_SYNC   = 8'h00;
   localparam logic [1:0]  RST_PIN_SENSE    = 2'h0;
   localparam logic        RST_LOW_LAT      = 1'h1;
   localparam logic        RST_MASTER_EN    = 1'h0;
   localparam logic [15:0] RST_PHASE        = 16'h0000;
endpackage

// ### core/pulse_conditioner.sv
/*
 * Resynchronises the alignment pulse pin and turns it into a per-cycle
 * request, either following the level or marking one chosen edge.
 * Assumes the pin is asynchronous to ref_clk and the mode bits are not.
 */
`timescale 1ns/1ns
module pulse_conditioner
   import sync_gate_pkg::*;
(
   // Clock and reset
   input  wire logic ref_clk,
   input  wire logic resetn,
   // Pin and mode
   input  wire logic syncPin,
   input  wire logic edgeMode,
   input  wire logic risingSel,
   // Conditioned request
   output logic      syncReq
);
   typedef struct packed {
      logic s1;
      logic s2;
      logic s3;
      logic stable;
      logic prev;
      logic req;
   } cond_state_t;

   cond_state_t st_q;
   cond_state_t st_d;

   always_comb begin
      st_d = st_q;
      st_d.s1 = syncPin;                                                 // RL14
      st_d.s2 = st_q.s1;
      st_d.s3 = st_q.s2;
      // A change counts only once the two later stages agree
      if (st_q.s2 == st_q.s3) begin
         st_d.stable = st_q.s3;
      end
      st_d.prev = st_q.stable;
      if (edgeMode) begin                                                // RL6
         if (risingSel) begin                                            // RL7
            st_d.req = st_q.stable & ~st_q.prev;
         end else begin
            st_d.req = ~st_q.stable & st_q.prev;
         end
      end else begin
         st_d.req = st_q.stable;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (!resetn) begin
         st_q <= '0;
      end else begin
         st_q <= st_d;
      end
   end

   assign syncReq = st_q.req;

   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!resetn);

   property p_level_follows;
      !edgeMode && st_q.stable |=> syncReq;
   endproperty
   a_level_follows: assert property (p_level_follows) else $error("level not followed"); // RL6

   property p_rising_edge;
      edgeMode && risingSel && st_q.stable && !st_q.prev |=> syncReq;
   endproperty
   a_rising_edge: assert property (p_rising_edge) else $error("rising edge missed"); // RL7

   property p_falling_only;
      edgeMode && !risingSel && st_q.stable |=> !syncReq;
   endproperty
   a_falling_only: assert property (p_falling_only) else $error("wrong edge taken"); // RL7

   property p_edge_single;
      edgeMode && $stable(edgeMode) && syncReq |=> !syncReq;
   endproperty
   a_edge_single: assert property (p_edge_single) else $error("edge pulse too long"); // RL14
endmodule

// ### core/sync_gating_ctrl.sv
/*
 * Gates the conditioned alignment pulse to the tunable oscillator, the
 * filter and the quarter-rate oscillator, and holds the related registers.
 * Assumes a register port already decoded from the serial configuration
 * port and running on the sample clock.
 */
`timescale 1ns/1ns
// Notes on behaviour
// RL1 - Filter enable passes every pulse, continuously
// RL2 - Filter one-shot: first pulse, then enable clears
// RL3 - Oscillator enable restarts it at phase offset
// RL4 - Oscillator one-shot clears its own enable
// RL5 - Master enable low blocks every stage
// RL6 - Sensitivity bit zero level, one edge
// RL7 - Edge select zero falling, one rising
// RL8 - Low-latency select bit picks low-latency oscillator
// RL9 - Host programs only two frequency words then
// RL10 - Host keeps configuration port quiet while sampling
// RL11 - Master enable needed; leave low to save power
// RL12 - Phase offset loaded on start or sync
// RL13 - Quarter-rate oscillator gated likewise, with one-shot
// RL14 - Pin resynchronised; edge-mode strobes last one cycle, level-mode ones while the pin is high
module sync_gating_ctrl
   import sync_gate_pkg::*;
(
   // Clock and reset
   input  wire logic        ref_clk,
   input  wire logic        resetn,
   // Alignment pulse pin
   input  wire logic        syncPin,
   // Register port
   input  wire logic [7:0]  regAddr,
   input  wire logic [7:0]  regWrData,
   input  wire logic        regWrEn,
   output logic      [7:0]  regRdData,
   // Oscillator start request from the datapath
   input  wire logic        oscStart,
   // Stage strobes and settings
   output logic             oscSyncStrobe,
   output logic             filterSyncStrobe,
   output logic             quarterSyncStrobe,
   output logic             phaseLoad,
   output logic      [15:0] phaseValue,
   output logic             lowLatencySelect
);
   typedef struct packed {
      logic                  masterEn;
      logic [7:0]            stageSync;
      logic [1:0]            pinSense;
      logic                  lowLat;
      logic [15:0]           phase;
      logic [NUM_STAGES-1:0] strobe;
      logic                  phaseLoad;
      logic [15:0]           phaseOut;
      logic [7:0]            rdData;
   } ctrl_state_t;

   ctrl_state_t st_q;
   ctrl_state_t st_d;
   logic        syncReq;

   pulse_conditioner u_cond (
      .ref_clk   (ref_clk),
      .resetn    (resetn),
      .syncPin   (syncPin),
      .edgeMode  (st_q.pinSense[PIN_SENSE_BIT]),
      .risingSel (st_q.pinSense[PIN_EDGE_BIT]),
      .syncReq   (syncReq)
   );

   always_comb begin
      st_d = st_q;
      st_d.strobe = '0;
      // One-shot self-clear comes first so a software write in the same
      // cycle wins and re-arming is never lost
      for (int c = 0; c < NUM_STAGES; c++) begin
         if (syncReq && st_q.masterEn && st_q.stageSync[STAGE_EN_BIT[c]]) begin // RL5 RL11
            st_d.strobe[c] = 1'b1;                                       // RL1 RL3 RL13
            if (st_q.stageSync[STAGE_EN_BIT[c] + 1]) begin
               st_d.stageSync[STAGE_EN_BIT[c]] = 1'b0;                   // RL2 RL4 RL13
            end
         end
      end
      // Phase offset goes out with every accepted oscillator sync or start
      st_d.phaseLoad = st_d.strobe[STAGE_OSC] | oscStart;                // RL12
      if (st_d.phaseLoad) begin
         st_d.phaseOut = st_q.phase;                                     // RL3 RL12
      end
      if (regWrEn) begin
         case (regAddr)
            ADDR_MASTER_SYNC: st_d.masterEn = regWrData[MASTER_EN_BIT];
            ADDR_PHASE_HI:    st_d.phase[15:8] = regWrData;
            ADDR_PHASE_LO:    st_d.phase[7:0] = regWrData;
            ADDR_STAGE_SYNC:  st_d.stageSync = regWrData & STAGE_SYNC_MASK;
            ADDR_PIN_SENSE:   st_d.pinSense = regWrData[1:0];
            ADDR_LATENCY_SEL: st_d.lowLat = regWrData[LOW_LAT_BIT];      // RL8
            default: ;
         endcase
      end
      case (regAddr)
         ADDR_MASTER_SYNC: st_d.rdData = {7'h00, st_q.masterEn};
         ADDR_PHASE_HI:    st_d.rdData = st_q.phase[15:8];
         ADDR_PHASE_LO:    st_d.rdData = st_q.phase[7:0];
         ADDR_STAGE_SYNC:  st_d.rdData = st_q.stageSync;
         ADDR_PIN_SENSE:   st_d.rdData = {6'h00, st_q.pinSense};
         ADDR_LATENCY_SEL: st_d.rdData = {7'h00, st_q.lowLat};
         default:          st_d.rdData = 8'h00;
      endcase
   end

   always_ff @(posedge ref_clk) begin
      if (!resetn) begin
         st_q.masterEn  <= RST_MASTER_EN;
         st_q.stageSync <= RST_STAGE_SYNC;
         st_q.pinSense  <= RST_PIN_SENSE;
         st_q.lowLat    <= RST_LOW_LAT;
         st_q.phase     <= RST_PHASE;
         st_q.strobe    <= '0;
         st_q.phaseLoad <= 1'b0;
         st_q.phaseOut  <= RST_PHASE;
         st_q.rdData    <= 8'h00;
      end else begin
         st_q <= st_d;
      end
   end

   assign oscSyncStrobe     = st_q.strobe[STAGE_OSC];
   assign filterSyncStrobe  = st_q.strobe[STAGE_FILTER];
   assign quarterSyncStrobe = st_q.strobe[STAGE_QUARTER];
   assign phaseLoad         = st_q.phaseLoad;
   assign phaseValue        = st_q.phaseOut;
   assign lowLatencySelect  = st_q.lowLat;
   assign regRdData         = st_q.rdData;

   // Checks
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!resetn);

   localparam int OSC_EN = STAGE_EN_BIT[STAGE_OSC];
   localparam int FIL_EN = STAGE_EN_BIT[STAGE_FILTER];
   localparam int QTR_EN = STAGE_EN_BIT[STAGE_QUARTER];

   logic stageWr;
   assign stageWr = regWrEn && (regAddr == ADDR_STAGE_SYNC);

   property p_filter_cont;
      syncReq && st_q.masterEn && st_q.stageSync[FIL_EN] |=> filterSyncStrobe;
   endproperty
   a_filter_cont: assert property (p_filter_cont) else $error("filter pulse dropped"); // RL1

   property p_filter_gated;
      !st_q.stageSync[FIL_EN] |=> !filterSyncStrobe;
   endproperty
   a_filter_gated: assert property (p_filter_gated) else $error("filter strobe not enabled"); // RL1

   property p_filter_once;
      syncReq && st_q.masterEn && st_q.stageSync[FIL_EN] && st_q.stageSync[FIL_EN + 1]
         && !stageWr |=> !st_q.stageSync[FIL_EN] ##1 !filterSyncStrobe;
   endproperty
   a_filter_once: assert property (p_filter_once) else $error("filter one-shot kept"); // RL2

   // Hardware self-clear must not swallow a re-arm written in the same cycle
   property p_write_wins;
      stageWr |=> st_q.stageSync == ($past(regWrData) & STAGE_SYNC_MASK);
   endproperty
   a_write_wins: assert property (p_write_wins) else $error("stage sync write lost"); // RL2

   property p_osc_cont;
      syncReq && st_q.masterEn && st_q.stageSync[OSC_EN]
         |=> oscSyncStrobe && phaseLoad && phaseValue == $past(st_q.phase);
   endproperty
   a_osc_cont: assert property (p_osc_cont) else $error("oscillator sync wrong"); // RL3

   property p_osc_gated;
      !st_q.stageSync[OSC_EN] |=> !oscSyncStrobe;
   endproperty
   a_osc_gated: assert property (p_osc_gated) else $error("oscillator strobe not enabled"); // RL3

   property p_osc_once;
      syncReq && st_q.masterEn && st_q.stageSync[OSC_EN] && st_q.stageSync[OSC_EN + 1]
         && !stageWr |=> !st_q.stageSync[OSC_EN];
   endproperty
   a_osc_once: assert property (p_osc_once) else $error("oscillator one-shot kept"); // RL4

   property p_master_block;
      !st_q.masterEn |=> !oscSyncStrobe && !filterSyncStrobe && !quarterSyncStrobe;
   endproperty
   a_master_block: assert property (p_master_block) else $error("strobe without master"); // RL5

   property p_low_latency;
      regWrEn && regAddr == ADDR_LATENCY_SEL
         |=> lowLatencySelect == $past(regWrData[LOW_LAT_BIT]);
   endproperty
   a_low_latency: assert property (p_low_latency) else $error("latency select not stored"); // RL8

   property p_phase_start;
      oscStart |=> phaseLoad && phaseValue == $past(st_q.phase);
   endproperty
   a_phase_start: assert property (p_phase_start) else $error("phase not loaded on start"); // RL12

   // Between loads the oscillator must keep seeing the same phase word
   property p_phase_hold;
      !phaseLoad |-> $stable(phaseValue);
   endproperty
   a_phase_hold: assert property (p_phase_hold) else $error("phase changed without load"); // RL12

   property p_quarter;
      syncReq && st_q.masterEn && st_q.stageSync[QTR_EN] |=> quarterSyncStrobe;
   endproperty
   a_quarter: assert property (p_quarter) else $error("quarter-rate pulse dropped"); // RL13

   property p_quarter_once;
      syncReq && st_q.masterEn && st_q.stageSync[QTR_EN] && st_q.stageSync[QTR_EN + 1]
         && !stageWr |=> !st_q.stageSync[QTR_EN];
   endproperty
   a_quarter_once: assert property (p_quarter_once) else $error("quarter one-shot kept"); // RL13

   property p_no_stray_strobe;
      !syncReq |=> !oscSyncStrobe && !filterSyncStrobe && !quarterSyncStrobe;
   endproperty
   a_no_stray_strobe: assert property (p_no_stray_strobe) else $error("strobe without pulse"); // RL14

   c_osc_sync:   cover property (oscSyncStrobe ##[1:20] oscSyncStrobe);
   c_filter_one: cover property (filterSyncStrobe ##1 !st_q.stageSync[FIL_EN]);
   c_quarter:    cover property (quarterSyncStrobe && filterSyncStrobe);
   c_level_run:  cover property (filterSyncStrobe [*3]);
   c_master_off: cover property (syncReq && !st_q.masterEn);
endmodule

// ### verification/sync_pulse_source.sv
/*
 * Model of the system timing source that drives the alignment pulse pin.
 * Assumes the pin idles low and the bench calls send() from one process.
 */
`timescale 1ns/1ns
module sync_pulse_source (
   // Clock
   input  wire logic ref_clk,
   // Pulse pin
   output logic      syncPin
);
   initial syncPin = 1'b0;
   // Offset from the edge so the pin is asynchronous; low time kept above two cycles
   task automatic send(input int cycles);
      @(posedge ref_clk);
      #13 syncPin = 1'b1;
      repeat (cycles) @(posedge ref_clk);
      #13 syncPin = 1'b0;
      repeat (4) @(posedge ref_clk);
   endtask
endmodule

// ### verification/dsp_sync_gating_control_tb_top.sv
/*
 * Self-checking bench for the alignment-pulse gating block.
 * Assumes the pulse source model drives the pin; inputs change on falling edges.
 */
`timescale 1ns/1ns
module dsp_sync_gating_control_tb_top
   import sync_gate_pkg::*;
;
   logic        ref_clk = 1'b0;
   logic        resetn = 1'b0;
   logic        regWrEn = 1'b0;
   logic        oscStart = 1'b0;
   logic [7:0]  regAddr = 8'h00;
   logic [7:0]  regWrData = 8'h00;
   logic [7:0]  regRdData;
   logic        syncPin, oscSyncStrobe, filterSyncStrobe, quarterSyncStrobe;
   logic        phaseLoad, lowLatencySelect;
   logic [15:0] phaseValue, phase;
   logic [7:0]  senseT [5] = '{8'h03, 8'h02, 8'h00, 8'h03, 8'h03};
   logic [7:0]  ctrlT [5]  = '{8'h51, 8'h51, 8'h51, 8'hf3, 8'h51};
   logic [7:0]  mastT [5]  = '{8'h01, 8'h01, 8'h01, 8'h01, 8'h00};
   int          fails = 0;
   int          checks = 0;
   int          nOsc, nFil, nQtr, nLd;

   always #20 ref_clk = ~ref_clk;

   sync_pulse_source i_sync_pulse_source (.ref_clk(ref_clk), .syncPin(syncPin));
   sync_gating_ctrl i_sync_gating_ctrl (
      .ref_clk(ref_clk), .resetn(resetn), .syncPin(syncPin), .regAddr(regAddr),
      .regWrData(regWrData), .regWrEn(regWrEn), .regRdData(regRdData),
      .oscStart(oscStart), .oscSyncStrobe(oscSyncStrobe),
      .filterSyncStrobe(filterSyncStrobe), .quarterSyncStrobe(quarterSyncStrobe),
      .phaseLoad(phaseLoad), .phaseValue(phaseValue), .lowLatencySelect(lowLatencySelect));

   // Counted on the falling edge, half a cycle after launch, so each strobe is read once settled
   always @(negedge ref_clk) begin
      nOsc += oscSyncStrobe;
      nFil += filterSyncStrobe;
      nQtr += quarterSyncStrobe;
      nLd += phaseLoad;
   end

   task automatic end_of_test;
      $display("Comparisons %0d, mismatches %0d", checks, fails);
      if (fails == 0 && checks > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask

   task automatic chkVal(input string n, input logic [15:0] e, g);
      checks++;
      if (g !== e) begin
         fails++;
         $display("Error %s expected %h seen %h", n, e, g);
      end
   endtask

   task automatic chkReg(input logic [7:0] a, e);
      @(negedge ref_clk);
      regAddr = a;
      @(negedge ref_clk);
      chkVal($sformatf("register %h", a), {8'h00, e}, {8'h00, regRdData});
   endtask

   task automatic wr(input logic [7:0] a, d);
      @(negedge ref_clk);
      regAddr = a;
      regWrData = d;
      regWrEn = 1'b1;
      @(negedge ref_clk);
      regWrEn = 1'b0;
   endtask

   // Strobes per burst: one-shot gives one, edge one per pulse, level one per high cycle
   function automatic logic [15:0] expCount(logic [7:0] sense, logic en, once, int n, w);
      if (!en) return 16'h0000;
      if (once) return 16'h0001;
      return sense[PIN_SENSE_BIT] ? 16'(n) : 16'(n * w);
   endfunction

   task automatic run(input logic [7:0] sense, ctrl, mast, input int n, w);
      wr(ADDR_PIN_SENSE, sense);
      wr(ADDR_MASTER_SYNC, mast);
      wr(ADDR_STAGE_SYNC, ctrl);
      nOsc = 0;
      nFil = 0;
      nQtr = 0;
      nLd = 0;
      // Registers are written only before the pulses arrive
      repeat (n) i_sync_pulse_source.send(w);
      repeat (8) @(negedge ref_clk);
      chkVal("osc", expCount(sense, ctrl[0] & mast[0], ctrl[1], n, w), 16'(nOsc));
      chkVal("fil", expCount(sense, ctrl[4] & mast[0], ctrl[5], n, w), 16'(nFil));
      chkVal("qtr", expCount(sense, ctrl[6] & mast[0], ctrl[7], n, w), 16'(nQtr));
      chkVal("load", expCount(sense, ctrl[0] & mast[0], ctrl[1], n, w), 16'(nLd));
   endtask

   initial begin
      void'($urandom(63836));
      repeat (3) @(negedge ref_clk);
      resetn = 1'b1;
      chkReg(ADDR_STAGE_SYNC, RST_STAGE_SYNC);
      chkReg(ADDR_PIN_SENSE, 8'h00);
      chkReg(ADDR_MASTER_SYNC, 8'h00);
      chkReg(ADDR_LATENCY_SEL, 8'h01);
      chkVal("lowLat", 16'h0001, {15'h0000, lowLatencySelect});
      chkReg(8'h10, 8'h00);
      wr(ADDR_STAGE_SYNC, 8'hff);
      chkReg(ADDR_STAGE_SYNC, STAGE_SYNC_MASK);
      // No frequency word is ever written, so low latency never meets an illegal one
      wr(ADDR_LATENCY_SEL, 8'h00);
      chkReg(ADDR_LATENCY_SEL, 8'h00);
      chkVal("lowLat", 16'h0000, {15'h0000, lowLatencySelect});
      phase = 16'($urandom);
      wr(ADDR_PHASE_HI, phase[15:8]);
      wr(ADDR_PHASE_LO, phase[7:0]);
      chkReg(ADDR_PHASE_HI, phase[15:8]);
      chkReg(ADDR_PHASE_LO, phase[7:0]);
      @(negedge ref_clk);
      oscStart = 1'b1;
      @(negedge ref_clk);
      oscStart = 1'b0;
      chkVal("phaseLoad", 16'h0001, {15'h0000, phaseLoad});
      chkVal("phaseValue", phase, phaseValue);
      for (int r = 0; r < 3; r++) begin
         for (int i = 0; i < 5; i++) begin
            run(senseT[i], ctrlT[i], mastT[i], 2, $urandom_range(6, 2));
            if (i == 3) chkReg(ADDR_STAGE_SYNC, 8'ha2);
         end
      end
      chkVal("phaseValue", phase, phaseValue);
      // Reset again mid-run: everything must fall back to its reset value
      resetn = 1'b0;
      repeat (3) @(negedge ref_clk);
      resetn = 1'b1;
      chkReg(ADDR_STAGE_SYNC, RST_STAGE_SYNC);
      chkReg(ADDR_LATENCY_SEL, 8'h01);
      chkVal("phaseValue", 16'h0000, phaseValue);
      end_of_test;
   end

   initial begin
      #(40 * 4000);
      fails++;
      end_of_test;
   end
endmodule
